/* File: hdl/eil_loader.v */
// Configuration image loader: reads the EEPROM header after reset and serves descriptors.
// Assumes a byte read engine on the same clock and an AXI4-Lite master for software.
`include "eil_regs.vh"

// What this block does
// - Image valid only if byte zero is A5
// - Bad marker: stop, keep every default value
// - Bytes one to six form station address
// - Byte 07h is full-speed poll interval
// - Byte 08h is high-speed poll interval
// - Byte 09h gives power, wakeup, LED flags
// - Language identifier from two bytes, low first
// - Five string length and offset pairs read
// - Word offset times two gives byte address
// - Zero length means descriptor absent, offset ignored
// - Four device and configuration pairs follow
// - Two bytes hold wake enables pins 10-0
// - Byte 20h gives power event signalling flags
// - String regions returned to host unchanged
// - Device descriptor region served as stored
// - USB stays detached until loading finishes
module eil_loader #(
  parameter EE_AW = 9
) (
  input wire sys_clk,
  input wire rst,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg ee_rd_req,
  output reg [EE_AW-1:0] ee_rd_addr,
  input wire ee_rd_ack,
  input wire [7:0] ee_rd_data,
  output reg usb_attach,
  output reg load_done,
  output reg image_valid,
  output reg [47:0] mac_addr,
  output reg [7:0] fs_poll_interval,
  output reg [7:0] hs_poll_interval,
  output reg [7:0] cfg_flags,
  output reg self_powered,
  output reg remote_wakeup_en,
  output reg led_select,
  output reg [15:0] lang_id,
  output reg [10:0] gpio_wake_en,
  output reg [7:0] pwr_evt_flags,
  output reg pwr_evt_en,
  output reg pwr_evt_pulse,
  output reg pwr_evt_push_pull
);

  // ---------------------------------------------------------------
  // States and helpers
  // ---------------------------------------------------------------
  localparam S_REQ = 3'h0;
  localparam S_WAIT = 3'h1;
  localparam S_IDLE = 3'h2;
  localparam S_DLEN = 3'h3;
  localparam S_DOFF = 3'h4;
  localparam S_DCHK = 3'h5;

  function [5:0] entry_addr;
    input [3:0] sel;
    input second;
    begin
      entry_addr = `EIL_A_TABLE + {sel, second};
    end
  endfunction

  function [EE_AW-1:0] byte_addr;
    input [7:0] woff;
    input [7:0] idx;
    begin
      byte_addr = {woff, 1'b0} + {1'b0, idx};
    end
  endfunction

  reg [2:0] state;
  reg [5:0] rd_ptr;
  reg aw_full;
  reg w_full;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [3:0] d_sel;
  reg [7:0] d_idx;
  reg [7:0] d_len;
  reg [7:0] d_data;
  reg d_busy;
  reg d_done;
  reg d_absent;
  reg mem_we;
  reg [5:0] mem_waddr;
  reg [7:0] mem_wdata;
  reg [5:0] mem_raddr;
  wire [7:0] mem_rdata;
  reg [31:0] rd_word;
  reg rd_hit;

  wire [2:0] mac_sel = rd_ptr[2:0] - 3'h1;
  wire wr_go = aw_full & w_full & ~s_axi_bvalid;
  wire [7:0] wr_word = {aw_addr_q[7:2], 2'b00};
  wire wr_hit = (wr_word <= `EIL_R_DDATA);
  wire launch = wr_go & (wr_word == `EIL_R_DCTRL) & w_strb_q[0] & load_done;
  wire [3:0] next_sel = w_strb_q[1] ? w_data_q[11:8] : d_sel;
  wire is_mac = (rd_ptr >= `EIL_A_MAC_FIRST) && (rd_ptr <= `EIL_A_MAC_LAST);
  wire is_table = (rd_ptr >= `EIL_A_TABLE) && (rd_ptr < `EIL_A_WAKE_LO);

  eil_mem #(
    .AW(6),
    .DW(8)
  ) u_hdr (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  // ---------------------------------------------------------------
  // Loader sequencer and register writes
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      state <= S_REQ;
      rd_ptr <= `EIL_A_MARK;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EIL_RESP_OKAY;
      d_sel <= 4'h0;
      d_idx <= 8'h00;
      d_len <= 8'h00;
      d_data <= 8'h00;
      d_busy <= 1'b0;
      d_done <= 1'b0;
      d_absent <= 1'b0;
      mem_we <= 1'b0;
      mem_waddr <= 6'h00;
      mem_wdata <= 8'h00;
      mem_raddr <= 6'h00;
      ee_rd_req <= 1'b0;
      ee_rd_addr <= {EE_AW{1'b0}};
      usb_attach <= 1'b0;
      load_done <= 1'b0;
      image_valid <= 1'b0;
      mac_addr <= `EIL_DEF_MAC;
      fs_poll_interval <= `EIL_DEF_BYTE;
      hs_poll_interval <= `EIL_DEF_BYTE;
      cfg_flags <= `EIL_DEF_BYTE;
      self_powered <= 1'b0;
      remote_wakeup_en <= 1'b0;
      led_select <= 1'b0;
      lang_id <= `EIL_DEF_LANG;
      gpio_wake_en <= `EIL_DEF_WAKE;
      pwr_evt_flags <= `EIL_DEF_BYTE;
      pwr_evt_en <= 1'b0;
      pwr_evt_pulse <= 1'b0;
      pwr_evt_push_pull <= 1'b0;
    end else if (ce) begin
      mem_we <= 1'b0;
      if (!aw_full) begin
        s_axi_awready <= 1'b1;
      end
      if (!w_full) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `EIL_RESP_OKAY : `EIL_RESP_SLVERR;
      end
      case (state)
        S_REQ: begin
          ee_rd_req <= 1'b1;
          if (!load_done) begin
            ee_rd_addr <= {{(EE_AW-6){1'b0}}, rd_ptr};
          end
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (ee_rd_ack) begin
            ee_rd_req <= 1'b0;
            if (load_done) begin
              d_data <= ee_rd_data;
              d_done <= 1'b1;
              d_busy <= 1'b0;
              state <= S_IDLE;
            end else if (rd_ptr == `EIL_A_MARK && ee_rd_data != `EIL_MARK_VAL) begin
              load_done <= 1'b1;
              image_valid <= 1'b0;
              usb_attach <= 1'b1;
              state <= S_IDLE;
            end else begin
              mem_we <= 1'b1;
              mem_waddr <= rd_ptr;
              mem_wdata <= ee_rd_data;
              if (is_mac) begin
                mac_addr[{mac_sel, 3'b000} +: 8] <= ee_rd_data;
              end
              if (is_table) begin
                mem_we <= 1'b1;
              end
              case (rd_ptr)
                `EIL_A_FS_INT: fs_poll_interval <= ee_rd_data;
                `EIL_A_HS_INT: hs_poll_interval <= ee_rd_data;
                `EIL_A_FLAGS: begin
                  cfg_flags <= ee_rd_data;
                  self_powered <= ee_rd_data[`EIL_F_SELF_PWR];
                  remote_wakeup_en <= ee_rd_data[`EIL_F_RWAKE];
                  led_select <= ee_rd_data[`EIL_F_LED_SEL];
                end
                `EIL_A_LANG_LO: lang_id[7:0] <= ee_rd_data;
                `EIL_A_LANG_HI: lang_id[15:8] <= ee_rd_data;
                `EIL_A_WAKE_LO: gpio_wake_en[7:0] <= ee_rd_data;
                `EIL_A_WAKE_HI: gpio_wake_en[10:8] <= ee_rd_data[2:0];
                `EIL_A_PWR: begin
                  pwr_evt_flags <= ee_rd_data;
                  pwr_evt_en <= ee_rd_data[`EIL_P_EN];
                  pwr_evt_pulse <= ee_rd_data[`EIL_P_PULSE];
                  pwr_evt_push_pull <= ee_rd_data[`EIL_P_PUSH_PULL];
                end
                default: begin
                end
              endcase
              if (rd_ptr == `EIL_A_PWR) begin
                load_done <= 1'b1;
                image_valid <= 1'b1;
                usb_attach <= 1'b1;
                state <= S_IDLE;
              end else begin
                rd_ptr <= rd_ptr + 6'h01;
                state <= S_REQ;
              end
            end
          end
        end
        S_IDLE: begin
          if (launch) begin
            d_idx <= w_data_q[7:0];
            d_sel <= next_sel;
            d_done <= 1'b0;
            d_absent <= 1'b0;
            if (!image_valid || next_sel >= `EIL_DESC_COUNT) begin
              d_done <= 1'b1;
              d_absent <= 1'b1;
            end else begin
              d_busy <= 1'b1;
              mem_raddr <= entry_addr(next_sel, 1'b0);
              state <= S_DLEN;
            end
          end
        end
        S_DLEN: begin
          mem_raddr <= entry_addr(d_sel, 1'b1);
          state <= S_DOFF;
        end
        S_DOFF: begin
          d_len <= mem_rdata;
          state <= S_DCHK;
        end
        S_DCHK: begin
          if (d_len == 8'h00 || d_idx >= d_len) begin
            d_absent <= 1'b1;
            d_done <= 1'b1;
            d_busy <= 1'b0;
            state <= S_IDLE;
          end else begin
            ee_rd_addr <= byte_addr(mem_rdata, d_idx);
            state <= S_REQ;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register read path
  // ---------------------------------------------------------------
  always @* begin
    rd_hit = 1'b1;
    rd_word = 32'h00000000;
    case ({s_axi_araddr[7:2], 2'b00})
      `EIL_R_STATUS: rd_word = {27'h0000000, d_absent, d_done, d_busy, image_valid, load_done};
      `EIL_R_MAC_LO: rd_word = mac_addr[31:0];
      `EIL_R_MAC_HI: rd_word = {16'h0000, mac_addr[47:32]};
      `EIL_R_CFG: rd_word = {pwr_evt_flags, cfg_flags, hs_poll_interval, fs_poll_interval};
      `EIL_R_LANG: rd_word = {5'h00, gpio_wake_en, lang_id};
      `EIL_R_DCTRL: rd_word = {20'h00000, d_sel, d_idx};
      `EIL_R_DDATA: rd_word = {16'h0000, d_len, d_data};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `EIL_RESP_OKAY;
    end else if (ce) begin
      if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `EIL_RESP_OKAY : `EIL_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: hdl/eil_mem.v */
// Small byte memory with a registered read port for the image header.
// Assumes one clock, a synchronous reset and a shared clock enable.
module eil_mem #(
  parameter AW = 6,
  parameter DW = 8
) (
  input wire sys_clk,
  input wire rst,
  input wire ce,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);

  reg [DW-1:0] store [0:(1<<AW)-1];

  always @(posedge sys_clk) begin
    if (ce && wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= {DW{1'b0}};
    end else if (ce) begin
      rd_data <= store[rd_addr];
    end
  end

endmodule

/* File: hdl/eil_regs.vh */
// Offsets, field positions and reset values of the configuration image loader.
// Assumes inclusion by bare name from the loader design files and the testbench top.
`ifndef EIL_REGS_VH
`define EIL_REGS_VH

// ---------------------------------------------------------------
// Image header byte locations
// ---------------------------------------------------------------
`define EIL_A_MARK 6'h00
`define EIL_MARK_VAL 8'hA5
`define EIL_A_MAC_FIRST 6'h01
`define EIL_A_MAC_LAST 6'h06
`define EIL_A_FS_INT 6'h07
`define EIL_A_HS_INT 6'h08
`define EIL_A_FLAGS 6'h09
`define EIL_A_LANG_LO 6'h0A
`define EIL_A_LANG_HI 6'h0B
`define EIL_A_TABLE 6'h0C
`define EIL_A_WAKE_LO 6'h1E
`define EIL_A_WAKE_HI 6'h1F
`define EIL_A_PWR 6'h20
`define EIL_DESC_COUNT 4'h9

// ---------------------------------------------------------------
// Flag bit positions
// ---------------------------------------------------------------
`define EIL_F_SELF_PWR 0
`define EIL_F_LED_SEL 1
`define EIL_F_RWAKE 2
`define EIL_P_PUSH_PULL 1
`define EIL_P_PULSE 6
`define EIL_P_EN 7

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define EIL_DEF_MAC 48'h000000000000
`define EIL_DEF_BYTE 8'h00
`define EIL_DEF_LANG 16'h0000
`define EIL_DEF_WAKE 11'h000

// ---------------------------------------------------------------
// Register byte addresses and responses
// ---------------------------------------------------------------
`define EIL_R_STATUS 8'h00
`define EIL_R_MAC_LO 8'h04
`define EIL_R_MAC_HI 8'h08
`define EIL_R_CFG 8'h0C
`define EIL_R_LANG 8'h10
`define EIL_R_DCTRL 8'h14
`define EIL_R_DDATA 8'h18
`define EIL_RESP_OKAY 2'h0
`define EIL_RESP_SLVERR 2'h2

`endif

/* File: tb/eil_ee_model.sv */
// Behavioural serial EEPROM answering byte reads after a variable wait.
// Assumes the loader's request is held until the acknowledge pulse.
module eil_ee_model (
  input wire logic sys_clk,
  input wire logic ee_rd_req,
  input wire logic [8:0] ee_rd_addr,
  input wire logic [1:0] lat,
  output logic ee_rd_ack,
  output logic [7:0] ee_rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:511];
  logic [1:0] wait_n = 2'h0;
  initial ee_rd_ack = 1'b0;
  initial ee_rd_data = 8'h00;
  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (ee_rd_req && !ee_rd_ack && wait_n >= lat) begin
      ee_rd_ack <= 1'b1;
      ee_rd_data <= mem[ee_rd_addr];
      wait_n <= 2'h0;
    end else begin
      ee_rd_ack <= 1'b0;
      ee_rd_data <= ~ee_rd_data;
      if (ee_rd_req && !ee_rd_ack) wait_n <= wait_n + 2'h1;
    end
  end
endmodule

/* File: tb/eil_loader_assertions.sv */
// Concurrent checks on the loader's EEPROM port and load status outputs.
// Assumes it is bound into every loader instance, one clock domain.
module eil_loader_assertions #(
  parameter EE_AW = 9
) (
  input wire sys_clk,
  input wire rst,
  input wire ee_rd_req,
  input wire [EE_AW-1:0] ee_rd_addr,
  input wire ee_rd_ack,
  input wire [7:0] ee_rd_data,
  input wire usb_attach,
  input wire load_done,
  input wire image_valid,
  input wire [47:0] mac_addr,
  input wire [15:0] lang_id,
  input wire [7:0] cfg_flags,
  input wire self_powered,
  input wire led_select,
  input wire remote_wakeup_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [EE_AW-1:0] last_addr;
  wire take = ee_rd_req && ee_rd_ack;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Helper logic and checks
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) last_addr <= '0;
    else if (take) last_addr <= ee_rd_addr;
  end
  chk_attach_done: assert property (usb_attach == load_done)
    else $error("usb attach differs from load done");
  chk_done_sticky: assert property (load_done |=> load_done && $stable(mac_addr))
    else $error("load done or address changed after load");
  chk_req_hold: assert property (ee_rd_req && !ee_rd_ack |=> ee_rd_req && $stable(ee_rd_addr))
    else $error("read request dropped before acknowledge");
  chk_req_gap: assert property (take |=> !ee_rd_req)
    else $error("read request not released after acknowledge");
  chk_marker_bad: assert property (take && !load_done && ee_rd_addr == 0 && ee_rd_data != 8'hA5
    |=> load_done && !image_valid)
    else $error("bad marker not ending the load");
  chk_hdr_end: assert property (take && ee_rd_addr == 9'h020 && !load_done
    |=> load_done && image_valid)
    else $error("load not flagged after last header byte");
  chk_bad_default: assert property (load_done && !image_valid
    |-> mac_addr == 48'h0 && lang_id == 16'h0 && !ee_rd_req)
    else $error("values loaded although marker failed");
  chk_flag_map: assert property (load_done
    |-> {remote_wakeup_en, led_select, self_powered} == cfg_flags[2:0])
    else $error("flag outputs differ from flag byte");
  chk_hdr_order: assert property (ee_rd_req && !load_done && ee_rd_addr != 0
    |-> ee_rd_addr == last_addr + 1'b1)
    else $error("header bytes not read in ascending order");
  cov_bad_marker: cover property (load_done && !image_valid);
  cov_good_load: cover property (load_done && image_valid);
  cov_desc_read: cover property (take && load_done);
endmodule

bind eil_loader eil_loader_assertions #(.EE_AW(EE_AW)) u_chk (.sys_clk, .rst, .ee_rd_req,
  .ee_rd_addr, .ee_rd_ack, .ee_rd_data, .usb_attach, .load_done, .image_valid, .mac_addr,
  .lang_id, .cfg_flags, .self_powered, .led_select, .remote_wakeup_en);

/* File: tb/eil_loader_tb_top.sv */
// Self-checking bench: random images, one bad marker, descriptor fetches.
// Assumes the loader, its checker and the EEPROM model are compiled first.
`include "eil_regs.vh"
module eil_loader_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] lat = 2'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire ee_rd_req, ee_rd_ack, usb_attach, load_done, image_valid;
  wire [8:0] ee_rd_addr;
  wire [7:0] ee_rd_data, fs_poll_interval, hs_poll_interval, cfg_flags, pwr_evt_flags;
  wire [47:0] mac_addr;
  wire [15:0] lang_id;
  wire [10:0] gpio_wake_en;
  wire self_powered, remote_wakeup_en, led_select, pwr_evt_en, pwr_evt_pulse;
  wire pwr_evt_push_pull;
  int mismatches = 0, checks_done = 0, cyc = 0, nreads = 0;
  logic vld;
  eil_loader u_dut (.sys_clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ee_rd_req, .ee_rd_addr, .ee_rd_ack, .ee_rd_data,
    .usb_attach, .load_done, .image_valid, .mac_addr, .fs_poll_interval, .hs_poll_interval,
    .cfg_flags, .self_powered, .remote_wakeup_en, .led_select, .lang_id, .gpio_wake_en,
    .pwr_evt_flags, .pwr_evt_en, .pwr_evt_pulse, .pwr_evt_push_pull);
  eil_ee_model u_ee (.sys_clk, .ee_rd_req, .ee_rd_addr, .lat, .ee_rd_ack, .ee_rd_data);
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) lat <= 2'($urandom_range(3));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic give_verdict;
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] hb(input int a);
    return vld ? u_ee.mem[a] : 8'h00;
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic ah, wh, got;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(negedge sys_clk);
      ah = s_axi_awready;
      wh = s_axi_wready;
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (got) s_axi_bready <= 1'b0;
    end
    @(posedge sys_clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(negedge sys_clk);
      ah = s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (got) s_axi_rready <= 1'b0;
    end
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  always @(negedge sys_clk) begin
    if (!rst && ee_rd_req && ee_rd_ack && !load_done) begin
      chk("header address", nreads, ee_rd_addr);
      nreads++;
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d, st;
    logic [1:0] rsp;
    logic [7:0] f9, w, p, ln, ix;
    logic ab;
    d = $urandom(32'hDBA3E6D5);
    for (int k = 0; k < 2; k++) begin
      vld = (k == 0);
      for (int i = 0; i < 512; i++) u_ee.mem[i] = 8'($urandom);
      u_ee.mem[0] = vld ? 8'hA5 : 8'($urandom_range(8'hA4));
      for (int s = 0; s < 9; s++) begin
        u_ee.mem[12 + 2 * s] = (s == 3) ? 8'h00 : 8'($urandom_range(18, 1));
        u_ee.mem[13 + 2 * s] = 8'(17 + 10 * s);
      end
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      nreads = 0;
      rst <= 1'b0;
      while (load_done !== 1'b1) @(posedge sys_clk);
      @(posedge sys_clk);
      f9 = hb(9);
      w = hb(31);
      p = hb(32);
      chk("status", {vld, 2'b11}, {image_valid, load_done, usb_attach});
      chk("reads", vld ? 33 : 1, nreads);
      chk("mac", {hb(6), hb(5), hb(4), hb(3), hb(2), hb(1)}, mac_addr);
      chk("fs poll", hb(7), fs_poll_interval);
      chk("hs poll", hb(8), hs_poll_interval);
      chk("flags", {f9, f9[2:0]}, {cfg_flags, remote_wakeup_en, led_select, self_powered});
      chk("lang", {hb(11), hb(10)}, lang_id);
      chk("wake", {w[2:0], hb(30)}, gpio_wake_en);
      chk("pwr", {p, p[7], p[6], p[1]}, {pwr_evt_flags, pwr_evt_en, pwr_evt_pulse,
        pwr_evt_push_pull});
      axi_rd(`EIL_R_MAC_LO, d, rsp);
      chk("mac lo reg", {`EIL_RESP_OKAY, hb(4), hb(3), hb(2), hb(1)}, {rsp, d});
      axi_rd(`EIL_R_MAC_HI, d, rsp);
      chk("mac hi reg", {`EIL_RESP_OKAY, 16'h0000, hb(6), hb(5)}, {rsp, d});
      axi_rd(`EIL_R_CFG, d, rsp);
      chk("cfg reg", {`EIL_RESP_OKAY, p, f9, hb(8), hb(7)}, {rsp, d});
      axi_rd(`EIL_R_LANG, d, rsp);
      chk("lang reg", {`EIL_RESP_OKAY, 5'h00, w[2:0], hb(30), hb(11), hb(10)}, {rsp, d});
      axi_rd(8'h1C, d, rsp);
      chk("unmapped", {`EIL_RESP_SLVERR, 32'h0}, {rsp, d});
      axi_wr(8'h1C, 32'h0, 4'hF, rsp);
      chk("unmapped write", `EIL_RESP_SLVERR, rsp);
      for (int s = 0; s < 10; s++) begin
        for (int j = 0; j < 3; j++) begin
          ln = (s < 9) ? hb(12 + 2 * s) : 8'h00;
          ix = (j == 0) ? 8'h00 : (j == 1 && ln != 0) ? 8'($urandom_range(ln - 1)) : ln;
          ab = (ln == 0) || (ix >= ln);
          axi_wr(`EIL_R_DCTRL, {20'h0, 4'(s), ix}, 4'hF, rsp);
          chk("ctrl write resp", `EIL_RESP_OKAY, rsp);
          st = 32'h0;
          while (!st[3]) axi_rd(`EIL_R_STATUS, st, rsp);
          axi_rd(`EIL_R_DDATA, d, rsp);
          chk("desc absent", ab, st[4]);
          if (!ab) chk("desc byte", {`EIL_RESP_OKAY, ln, u_ee.mem[2 * hb(13 + 2 * s) + ix]},
            {rsp, d[15:0]});
        end
      end
      axi_wr(`EIL_R_DCTRL, 32'h0, 4'h2, rsp);
      axi_rd(`EIL_R_STATUS, st, rsp);
      chk("refused fetch", 2'b10, st[3:2]);
      axi_rd(`EIL_R_DCTRL, d, rsp);
      chk("refused select", 32'h00000900, d);
    end
    give_verdict();
  end
endmodule
